/* design/lcc_cluster.sv */
// one logic cluster: ten cells, local interconnect, chains, control generator
`timescale 1ns/10ps

module lcc_cluster (
   input  wire logic                           clk,
   input  wire logic                           rstn,
   input  wire logic [lcc_pkg::ADDR_W-1:0]     addr,
   input  wire logic [lcc_pkg::DATA_W-1:0]     wdata,
   input  wire logic                           wr_en,
   input  wire logic                           rd_en,
   output      logic [lcc_pkg::DATA_W-1:0]     rdata,
   input  wire logic [lcc_pkg::NCOL-1:0]       col_clk,
   input  wire logic [lcc_pkg::NEXT-1:0]       ext_in,
   input  wire logic [lcc_pkg::NCELL-1:0]      nbr_left_in,
   input  wire logic [lcc_pkg::NCELL-1:0]      nbr_right_in,
   input  wire logic                           carry_in,
   output      logic [lcc_pkg::NCELL-1:0]      cell_q,
   output      logic                           carry_out
);

   typedef struct packed {
      logic [lcc_pkg::NCELL-1:0][lcc_pkg::CFG_W-1:0]   cell_cfg;
      logic [lcc_pkg::NCELL-1:0][lcc_pkg::INSEL_W-1:0] in_sel;
      logic [lcc_pkg::NCTL-1:0][lcc_pkg::CTL_W-1:0]    ctl_cfg;
      logic [lcc_pkg::NCELL-1:0]                       q;
      logic [1:0]                                      clk_prev;
      logic                                            carry;
      logic [lcc_pkg::DATA_W-1:0]                      rdata;
   } lcc_state_s;

   lcc_state_s                      st_q;
   lcc_state_s                      st_d;
   logic [1:0]                      rst_sync_q;
   logic                            rst_n_int;
   logic [lcc_pkg::POOL_W-1:0]      pool;
   logic [lcc_pkg::NCTL-1:0]        ctl_val;
   logic [1:0]                      clk_lvl;
   logic [1:0]                      tick;
   logic [lcc_pkg::NCELL:0]         carry;
   logic [lcc_pkg::NCELL-1:0]       lut_out;
   logic [lcc_pkg::NCELL-1:0]       lut_link;
   logic [lcc_pkg::NCELL-1:0]       reg_link;
   logic [lcc_pkg::NCELL-1:0]       q_nxt;
   logic [lcc_pkg::NCELL-1:0]       tick_sel;
   logic [lcc_pkg::NCELL-1:0]       aclr_eff;
   logic [lcc_pkg::NCELL-1:0]       aload_eff;
   logic [1:0]                      region;
   logic [3:0]                      idx;
   logic                            idx_ok;

   // reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n_int = rst_sync_q[1];

   // shared source pool: feedback lines are registered outputs only, which
   // keeps any configuration free of combinational loops through the pool
   assign pool = {4'h0, nbr_right_in, nbr_left_in, st_q.q, ext_in, col_clk};

   // control generator: each slot picks one pool line, optionally inverted
   for (genvar c = 0; c < lcc_pkg::NCTL; c++) begin : g_ctl
      always_comb begin
         if (st_q.ctl_cfg[c][lcc_pkg::CTL_USED]) begin
            ctl_val[c] = pool[st_q.ctl_cfg[c][lcc_pkg::SRC_W-1:0]]
                         ^ st_q.ctl_cfg[c][lcc_pkg::CTL_INV];
         end else begin
            ctl_val[c] = lcc_pkg::CTL_IDLE[c];
         end
      end
   end

   // cluster clocks: an inverted slot gives the falling edge, so one column
   // clock on both slots serves rising and falling registers together
   assign clk_lvl = {ctl_val[lcc_pkg::CTL_CLK1], ctl_val[lcc_pkg::CTL_CLK0]};
   assign tick[0] = clk_lvl[0] & ~st_q.clk_prev[0] & ctl_val[lcc_pkg::CTL_ENA0];
   assign tick[1] = clk_lvl[1] & ~st_q.clk_prev[1] & ctl_val[lcc_pkg::CTL_ENA1];

   // carry into the first cell is forced high while subtracting
   assign carry[0] = ctl_val[lcc_pkg::CTL_ADDSUB] ? 1'b1 : carry_in;

   // chains come only from the previous cell; cell 0 sees zero
   assign lut_link = {lut_out[lcc_pkg::NCELL-2:0], 1'b0};
   assign reg_link = {st_q.q[lcc_pkg::NCELL-2:0], 1'b0};

   // ten logic cells, one per loop entry
   for (genvar i = 0; i < lcc_pkg::NCELL; i++) begin : g_cell
      logic [lcc_pkg::CFG_W-1:0] cfg;
      logic [lcc_pkg::NIN-1:0]   d_raw;
      logic                      d3;
      logic                      b_op;
      logic                      comb;
      logic                      din;
      logic                      ld;
      logic                      sync_on;

      assign cfg = st_q.cell_cfg[i];
      for (genvar k = 0; k < lcc_pkg::NIN; k++) begin : g_in
         assign d_raw[k] = pool[st_q.in_sel[i][k*lcc_pkg::SRC_W +: lcc_pkg::SRC_W]];
      end
      assign d3 = cfg[lcc_pkg::F_LUTCHAIN] ? lut_link[i] : d_raw[3];
      assign lut_out[i] = cfg[{d3, d_raw[2:0]}];

      // dynamic adder/subtractor: second operand flips while subtracting
      assign b_op = d_raw[1] ^ ctl_val[lcc_pkg::CTL_ADDSUB];
      assign carry[i+1] = cfg[lcc_pkg::F_ARITH]
                          & ((d_raw[0] & b_op) | (carry[i] & (d_raw[0] ^ b_op)));
      assign comb = cfg[lcc_pkg::F_ARITH] ? (d_raw[0] ^ b_op ^ carry[i]) : lut_out[i];
      assign din = cfg[lcc_pkg::F_REGCHAIN] ? reg_link[i] : comb;
      assign ld = cfg[lcc_pkg::F_ADATA_ONE] ? 1'b1 : d3;
      assign sync_on = cfg[lcc_pkg::F_SYNC];

      // per-cell control selection
      assign tick_sel[i] = cfg[lcc_pkg::F_CLKSEL] ? tick[1] : tick[0];
      assign aclr_eff[i] = cfg[lcc_pkg::F_CLRSEL] ? ctl_val[lcc_pkg::CTL_ACLR1]
                                                   : ctl_val[lcc_pkg::CTL_ACLR0];
      assign aload_eff[i] = cfg[lcc_pkg::F_ALOAD] & ctl_val[lcc_pkg::CTL_ALOAD];

      // register next value: async controls act every cycle, sync ones on ticks
      always_comb begin
         q_nxt[i] = st_q.q[i];
         if (aclr_eff[i]) begin
            q_nxt[i] = cfg[lcc_pkg::F_INV];
         end else if (aload_eff[i]) begin
            q_nxt[i] = ld;
         end else if (tick_sel[i]) begin
            if (sync_on && ctl_val[lcc_pkg::CTL_SCLR]) begin
               q_nxt[i] = 1'b0;
            end else if (sync_on && ctl_val[lcc_pkg::CTL_SLOAD]) begin
               q_nxt[i] = d3;
            end else begin
               q_nxt[i] = din;
            end
         end
      end
   end

   // register address split; words are aligned, index must name an entry
   assign region = addr[7:6];
   assign idx    = addr[5:2];
   assign idx_ok = (addr[1:0] == 2'h0) && (idx < 4'(lcc_pkg::NCELL));

   // next state: cells, clock history, carry, and the register port
   always_comb begin
      st_d          = st_q;
      st_d.q        = q_nxt;
      st_d.clk_prev = clk_lvl;
      st_d.carry    = carry[lcc_pkg::NCELL];
      st_d.rdata    = '0;   // read data stand only in the cycle after a read
      if (wr_en && idx_ok) begin
         if (region == lcc_pkg::REG_CELL) begin
            st_d.cell_cfg[idx] = wdata[lcc_pkg::CFG_W-1:0];
         end else if (region == lcc_pkg::REG_INSEL) begin
            st_d.in_sel[idx] = wdata[lcc_pkg::INSEL_W-1:0];
         end else if (region == lcc_pkg::REG_CTL) begin
            st_d.ctl_cfg[idx] = wdata[lcc_pkg::CTL_W-1:0];
         end
      end
      if (rd_en) begin
         if (addr == lcc_pkg::ADDR_STATUS) begin
            st_d.rdata[lcc_pkg::ST_Q_LSB +: lcc_pkg::NCELL] = st_q.q;
            st_d.rdata[lcc_pkg::ST_CARRY] = st_q.carry;
            st_d.rdata[lcc_pkg::ST_CTL_LSB +: lcc_pkg::NCTL] = ctl_val;
         end else if (idx_ok && region == lcc_pkg::REG_CELL) begin
            st_d.rdata[lcc_pkg::CFG_W-1:0] = st_q.cell_cfg[idx];
         end else if (idx_ok && region == lcc_pkg::REG_INSEL) begin
            st_d.rdata[lcc_pkg::INSEL_W-1:0] = st_q.in_sel[idx];
         end else if (idx_ok && region == lcc_pkg::REG_CTL) begin
            st_d.rdata[lcc_pkg::CTL_W-1:0] = st_q.ctl_cfg[idx];
         end
      end
   end

   // single state register
   always_ff @(posedge clk or negedge rst_n_int) begin
      if (!rst_n_int) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign cell_q    = st_q.q;       // also the neighbour link toward both sides
   assign carry_out = st_q.carry;
   assign rdata     = st_q.rdata;

   // checks
   sequence s_status_read;
      rd_en && (addr == lcc_pkg::ADDR_STATUS);
   endsequence

   // cell 6 is the one the bench puts on the register chain
   sequence s_chain_shift;
      tick_sel[6] && !aclr_eff[6] && !aload_eff[6] && !st_q.cell_cfg[6][lcc_pkg::F_SYNC]
      && st_q.cell_cfg[6][lcc_pkg::F_REGCHAIN];
   endsequence

   property p_ena_gate;
      @(posedge clk) disable iff (!rst_n_int)
      !ctl_val[lcc_pkg::CTL_ENA0] |-> !tick[0];
   endproperty
   a_ena_gate: assert property (p_ena_gate) else $error("edge passed a low enable");

   property p_pair;
      @(posedge clk) disable iff (!rst_n_int)
      (tick_sel[0] && !st_q.cell_cfg[0][lcc_pkg::F_CLKSEL])
      |-> ctl_val[lcc_pkg::CTL_ENA0] && clk_lvl[0] && !st_q.clk_prev[0];
   endproperty
   a_pair: assert property (p_pair) else $error("cell tick without paired enable");

   property p_aclr;
      @(posedge clk) disable iff (!rst_n_int)
      (aclr_eff[0] && !st_q.cell_cfg[0][lcc_pkg::F_INV]) |=> !cell_q[0];
   endproperty
   a_aclr: assert property (p_aclr) else $error("async clear did not clear");

   property p_pushback;
      @(posedge clk) disable iff (!rst_n_int)
      (aclr_eff[8] && st_q.cell_cfg[8][lcc_pkg::F_INV]) |=> cell_q[8];
   endproperty
   a_pushback: assert property (p_pushback) else $error("push-back clear not high");

   property p_aload_one;
      @(posedge clk) disable iff (!rst_n_int)
      (!aclr_eff[2] && aload_eff[2] && st_q.cell_cfg[2][lcc_pkg::F_ADATA_ONE]) |=> cell_q[2];
   endproperty
   a_aload_one: assert property (p_aload_one) else $error("preset load not high");

   property p_sub_carry;
      @(posedge clk) disable iff (!rst_n_int)
      ctl_val[lcc_pkg::CTL_ADDSUB] |-> carry[0];
   endproperty
   a_sub_carry: assert property (p_sub_carry) else $error("subtract carry not one");

   property p_hold;
      @(posedge clk) disable iff (!rst_n_int)
      (!aclr_eff[0] && !aload_eff[0] && !tick_sel[0]) |=> $stable(cell_q[0]);
   endproperty
   a_hold: assert property (p_hold) else $error("register moved without edge");

   property p_chain;
      @(posedge clk) disable iff (!rst_n_int)
      s_chain_shift |=> cell_q[6] == $past(cell_q[5]);
   endproperty
   a_chain: assert property (p_chain) else $error("register chain did not shift");

   property p_status;
      @(posedge clk) disable iff (!rst_n_int)
      s_status_read |=> rdata[lcc_pkg::ST_Q_LSB +: lcc_pkg::NCELL] == $past(cell_q);
   endproperty
   a_status: assert property (p_status) else $error("status read wrong");

endmodule // lcc_cluster

/* shared/lcc_pkg.sv */
// constants for the logic cluster control fabric
package lcc_pkg;

   // cluster geometry
   localparam int NCELL   = 10;              // logic cells per cluster
   localparam int NEXT    = 26;              // distinct external inputs
   localparam int NCOL    = 4;               // column clock lines
   localparam int NCTL    = 10;              // control slots of the generator
   localparam int NIN     = 4;               // data inputs per logic cell
   localparam int SRC_W   = 6;               // width of a source selector
   localparam int POOL_W  = 64;              // entries of the source pool

   // source pool layout: col clocks, external, feedback, left, right
   localparam int SRC_COL   = 0;
   localparam int SRC_EXT   = 4;
   localparam int SRC_FB    = 30;
   localparam int SRC_LEFT  = 40;
   localparam int SRC_RIGHT = 50;

   // logic cell configuration word
   localparam int CFG_W       = 25;
   localparam int LUT_W       = 16;
   localparam int F_CLKSEL    = 16;          // 0: first clock pair, 1: second
   localparam int F_CLRSEL    = 17;          // 0: first async clear, 1: second
   localparam int F_INV       = 18;          // push-back: clear drives high
   localparam int F_ALOAD     = 19;          // honour cluster async load
   localparam int F_ADATA_ONE = 20;          // async load data held at one
   localparam int F_ARITH     = 21;          // adder/subtractor cell
   localparam int F_REGCHAIN  = 22;          // register fed by previous cell
   localparam int F_LUTCHAIN  = 23;          // data3 taken from previous lookup
   localparam int F_SYNC      = 24;          // honour sync clear and sync load
   localparam int INSEL_W     = NIN * SRC_W;

   // control slot word
   localparam int CTL_W    = 8;
   localparam int CTL_USED = 7;
   localparam int CTL_INV  = 6;

   // control slot indices
   localparam int CTL_CLK0  = 0;
   localparam int CTL_CLK1  = 1;
   localparam int CTL_ENA0  = 2;
   localparam int CTL_ENA1  = 3;
   localparam int CTL_ACLR0 = 4;
   localparam int CTL_ACLR1 = 5;
   localparam int CTL_SCLR  = 6;
   localparam int CTL_ALOAD = 7;
   localparam int CTL_SLOAD = 8;
   localparam int CTL_ADDSUB = 9;
   localparam logic [NCTL-1:0] CTL_IDLE = 10'h00c;  // unused enables read high

   // register map
   localparam int          ADDR_W      = 8;
   localparam int          DATA_W      = 32;
   localparam logic [1:0]  REG_CELL    = 2'h0;      // 8'h00 + 4*cell
   localparam logic [1:0]  REG_INSEL   = 2'h1;      // 8'h40 + 4*cell
   localparam logic [1:0]  REG_CTL     = 2'h2;      // 8'h80 + 4*slot
   localparam logic [7:0]  ADDR_STATUS = 8'hc0;

   // status word fields
   localparam int ST_Q_LSB   = 0;
   localparam int ST_CARRY   = 10;
   localparam int ST_CTL_LSB = 11;

endpackage

/* dv/lcc_nbr_model.sv */
// neighbour clusters and global clock lines facing one logic cluster
`timescale 1ns/10ps

module lcc_nbr_model (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic [3:0] pulse,
   input  wire logic [9:0] left_val,
   input  wire logic [9:0] right_val,
   output      logic [3:0] col_clk,
   output      logic [9:0] nbr_left_in,
   output      logic [9:0] nbr_right_in
);
   // four global lines, each high one cycle per request and low between
   // neighbour cell outputs are registered, like a real cluster's outputs
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         col_clk      <= 4'h0;
         nbr_left_in  <= 10'h000;
         nbr_right_in <= 10'h000;
      end else begin
         col_clk      <= pulse;
         nbr_left_in  <= left_val;
         nbr_right_in <= right_val;
      end
   end
endmodule // lcc_nbr_model

/* dv/test_logic_cluster_control_fabric.sv */
// self-checking bench for the logic cluster control fabric
`timescale 1ns/10ps

module test_logic_cluster_control_fabric;
   logic        clk;
   logic        rstn;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic        wr_en;
   logic        rd_en;
   logic [31:0] rdata;
   logic [25:0] ext_in;
   logic        carry_in;
   logic [9:0]  cell_q;
   logic        carry_out;
   logic [3:0]  col_clk;
   logic [3:0]  pulse;
   logic [9:0]  left_val;
   logic [9:0]  right_val;
   logic [9:0]  nbr_l;
   logic [9:0]  nbr_r;
   logic [31:0] v;
   int          n_errors;
   int          num_checks;
   int          cyc = 0;
   // per cell: arith, right link, async load one, sync, pair 1, plain, reg chain,
   // left link, push-back on clear 0, push-back on clear 1
   logic [31:0] cfg [10] = '{32'h00200000, 32'h0000aaaa, 32'h00180000, 32'h0100ffff,
      32'h0001ffff, 32'h0000ffff, 32'h00400000, 32'h0000aaaa, 32'h00040000, 32'h00060000};
   logic [31:0] insel [10] = '{32'h00000289, 32'h00000034, 32'h0, 32'h0, 32'h0, 32'h0,
      32'h0, 32'h00000028, 32'h0, 32'h0};
   // slots: clk0 col0, clk1 col1, ena0 ext3, aclr0 ext0, aclr1 ext1, sclr ext4,
   // aload ext2, addsub ext7; ena1 and sload left unused
   logic [7:0]  slot [10] = '{8'h80, 8'h81, 8'h87, 8'h00, 8'h84, 8'h85, 8'h88, 8'h86,
      8'h00, 8'h8b};
   // arithmetic rows: {a, b, carry in, subtract, expected sum}
   logic [4:0]  rows [8] = '{5'h00, 5'h11, 5'h18, 5'h14, 5'h02, 5'h13, 5'h1a, 5'h0b};

   lcc_cluster u_lcc_cluster (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .col_clk(col_clk), .ext_in(ext_in),
      .nbr_left_in(nbr_l), .nbr_right_in(nbr_r), .carry_in(carry_in), .cell_q(cell_q),
      .carry_out(carry_out));

   lcc_nbr_model u_lcc_nbr_model (.clk(clk), .rstn(rstn), .pulse(pulse),
      .left_val(left_val), .right_val(right_val), .col_clk(col_clk),
      .nbr_left_in(nbr_l), .nbr_right_in(nbr_r));

   // free-running clock, 8 ns period
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // whole run needs well under a thousand cycles; the ceiling leaves slack
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         report_and_stop();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // each bus task starts on a fresh edge, so strobes are never assigned twice at once
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe; taken mid-cycle
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      rd_en <= 1'b1;
      addr  <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask

   task automatic setx(input int n, input logic b);
      @(posedge clk);
      ext_in[n] <= b;
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask

   // one-cycle pulse on the chosen global lines, then let the tick land
   task automatic tick(input logic [3:0] m);
      @(posedge clk);
      pulse <= m;
      @(posedge clk);
      pulse <= 4'h0;
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask

   initial begin
      rstn = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      ext_in = 26'h0;
      carry_in = 1'b0;
      pulse = 4'h0;
      left_val = 10'h001;
      right_val = 10'h004;
      n_errors = 0;
      num_checks = 0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(32'(cell_q), 32'h0);
      rd(8'hc0, v);
      chk(v, {11'h000, lcc_pkg::CTL_IDLE, 11'h000});
      $display("test reset done");
      for (int i = 0; i < 10; i++) begin
         wr(8'(4 * i), cfg[i]);
         wr(8'h40 + 8'(4 * i), insel[i]);
         wr(8'h80 + 8'(4 * i), {24'h0, slot[i]});
      end
      // asynchronous clears and load act without any cluster clock
      setx(0, 1'b1);
      chk(32'(cell_q & 10'h300), 32'h100);
      setx(0, 1'b0);
      setx(1, 1'b1);
      chk(32'(cell_q & 10'h300), 32'h300);
      setx(1, 1'b0);
      setx(2, 1'b1);
      chk(32'(cell_q[2]), 32'h1);
      setx(2, 1'b0);
      $display("test async done");
      // first pair gated off, second pair unaffected by the first enable
      tick(4'h1);
      chk(32'(cell_q & 10'h0fa), 32'h0);
      tick(4'h2);
      chk(32'(cell_q & 10'h0fa), 32'h010);
      setx(3, 1'b1);
      tick(4'h1);
      chk(32'(cell_q & 10'h0fa), 32'h0ba);
      tick(4'h1);
      chk(32'(cell_q & 10'h0fa), 32'h0fa);
      $display("test clocking done");
      // sync clear is refused while the enable is low
      setx(4, 1'b1);
      setx(3, 1'b0);
      tick(4'h1);
      chk(32'(cell_q[3]), 32'h1);
      setx(3, 1'b1);
      tick(4'h1);
      chk(32'(cell_q[3]), 32'h0);
      setx(4, 1'b0);
      $display("test sync done");
      foreach (rows[k]) begin
         @(posedge clk);
         ext_in[5] <= rows[k][4];
         ext_in[6] <= rows[k][3];
         carry_in  <= rows[k][2];
         ext_in[7] <= rows[k][1];
         tick(4'h1);
         chk(32'(cell_q[0]), 32'(rows[k][0]));
      end
      chk(32'(carry_out), 32'h0);
      $display("test arith done");
      rd(8'h0c, v);
      chk(v, 32'h0100ffff);
      wr(8'h28, 32'h0000ffff);
      rd(8'h28, v);
      chk(v, 32'h0);
      rd(8'hc4, v);
      chk(v, 32'h0);
      wr(8'h14, 32'hffffffff);
      rd(8'h14, v);
      chk(v, 32'h01ffffff);
      @(negedge clk);
      chk(rdata, 32'h0);
      $display("test bus done");
      // second clock slot inverted on column 0: its tick comes on the falling edge;
      // slot first, so the edge that the rewrite itself makes finds cell 4 unchanged
      wr(8'h84, 32'h000000c0);
      wr(8'h10, 32'h00010000);
      // cell 3 zero lookup under sync load; cell 2 follows cell 1 over the lookup chain
      wr(8'h0c, 32'h01000000);
      wr(8'ha0, 32'h0000008c);
      wr(8'h08, 32'h0080ff00);
      wr(8'h48, 32'h00f00000);
      setx(8, 1'b1);
      tick(4'h1);
      chk(32'(cell_q[4]), 32'h0);
      chk(32'(cell_q[3]), 32'h1);
      chk(32'(cell_q[2]), 32'h1);
      $display("test edges done");
      report_and_stop();
   end
endmodule // test_logic_cluster_control_fabric
